// ### mor_top.sv
// modem option register bank with sleep and terminal-ready timing
`timescale 1ns/1ps
module mor_top
  import mor_pkg::*;
#(
  parameter int TICK_PERIOD = mor_pkg::TICK_CYCLES
) (
  input wire logic CLK_SYS,
  input wire logic RESET,
  input wire logic FACTORY_DEFAULTS,
  input wire logic [2:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [7:0] REG_RDATA,
  input wire logic AUTO_ANSWER_DISCRIM_CMD,
  input wire logic AUTO_ANSWER_DISCRIM_SET,
  input wire logic [1:0] GUARD_TONE_VALUE,
  input wire logic GUARD_TONE_CMD,
  input wire logic ACTIVITY,
  input wire logic CONNECTED,
  input wire logic ON_LINE,
  input wire logic TERMINAL_READY,
  input wire logic REMOTE_LOOP_REQ,
  output logic REMOTE_LOOP_ACCEPT,
  output logic [1:0] LINE_RATE,
  output logic [1:0] PARITY_SEL,
  output logic [1:0] GUARD_TONE_SEL,
  output logic SYNC_MODE,
  output logic LEASED_LINE,
  output logic [1:0] TX_CLOCK_SRC,
  output logic BELL_STANDARD,
  output logic DISCRIM_ENABLE,
  output logic SLEEP_ENTER,
  output logic TERMINAL_READY_VALID,
  output logic TERMINAL_READY_FILT
);
  import mor_pkg::*;

  // ****************************************
  // registers
  // ****************************************
  logic [7:0] loop_rate_q;
  logic [7:0] sleep_tmr_q;
  logic [7:0] trdy_dly_q;
  logic [7:0] mode_q;
  logic restore;
  assign restore = RESET || FACTORY_DEFAULTS;

  always_ff @(posedge CLK_SYS) begin
    if (restore) begin
      loop_rate_q <= LOOP_RATE_RST;
    end else if (GUARD_TONE_CMD) begin
      loop_rate_q[GUARD_LO +: 2] <= GUARD_TONE_VALUE;
    end else if (REG_WR && REG_ADDR == LOOP_RATE_OFS) begin
      loop_rate_q <= REG_WDATA;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (restore) begin
      sleep_tmr_q <= SLEEP_TMR_RST;
    end else if (REG_WR && REG_ADDR == SLEEP_TMR_OFS) begin
      sleep_tmr_q <= REG_WDATA;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (restore) begin
      trdy_dly_q <= TRDY_DLY_RST;
    end else if (REG_WR && REG_ADDR == TRDY_DLY_OFS) begin
      trdy_dly_q <= REG_WDATA;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (restore) begin
      mode_q <= MODE_RST;
    end else if (AUTO_ANSWER_DISCRIM_CMD) begin
      mode_q[DISCRIM_BIT] <= AUTO_ANSWER_DISCRIM_SET;
    end else if (REG_WR && REG_ADDR == MODE_OFS) begin
      mode_q <= REG_WDATA;
    end
  end

  // ****************************************
  // decoded options, reserved codes fall back to defaults
  // ****************************************
  logic [1:0] rate_f;
  logic [1:0] par_f;
  logic [1:0] guard_f;
  logic [2:0] comm_f;
  logic [1:0] rate_d;
  assign rate_f = loop_rate_q[RATE_LO +: 2];
  assign par_f = loop_rate_q[PAR_LO +: 2];
  assign guard_f = loop_rate_q[GUARD_LO +: 2];
  assign comm_f = {mode_q[3], mode_q[1:0]};

  // the reserved rate code runs at the default rate
  always_comb begin
    case (rate_f)
      2'h1: rate_d = RATE_2400;
      default: rate_d = rate_f;
    endcase
  end

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      REMOTE_LOOP_ACCEPT <= 1'b0;
    end else begin
      // accept only when a request arrives and bit 0 allows it
      REMOTE_LOOP_ACCEPT <= REMOTE_LOOP_REQ && loop_rate_q[RDL_BIT];
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      LINE_RATE <= RATE_2400;
    end else begin
      LINE_RATE <= rate_d;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      PARITY_SEL <= PAR_EVEN;
    end else begin
      PARITY_SEL <= par_f;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      GUARD_TONE_SEL <= 2'h0;
    end else begin
      GUARD_TONE_SEL <= guard_f;
    end
  end

  // sync modes, leased lines and outside clocks are unsupported, so the
  // datapath stays async on dial-up with the internal clock
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      SYNC_MODE <= 1'b0;
      LEASED_LINE <= 1'b0;
      TX_CLOCK_SRC <= CLK_INTERNAL;
    end else begin
      SYNC_MODE <= 1'b0;
      LEASED_LINE <= 1'b0;
      TX_CLOCK_SRC <= CLK_INTERNAL;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      BELL_STANDARD <= 1'b1;
    end else begin
      BELL_STANDARD <= mode_q[STD_BIT];
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      DISCRIM_ENABLE <= 1'b0;
    end else begin
      DISCRIM_ENABLE <= mode_q[DISCRIM_BIT];
    end
  end

  // ****************************************
  // timebase
  // ****************************************
  logic tick;
  mor_tick #(
    .PERIOD(TICK_PERIOD)
  ) u_tick (
    .clk(CLK_SYS),
    .rst(RESET),
    .tick(tick)
  );

  // ****************************************
  // sleep inactivity
  // ****************************************
  // the second count restarts with each quiet spell, so the delay runs
  // from the last activity rather than from a free-running second edge
  logic [6:0] idle_sub_q;
  logic idle_sec;
  logic [7:0] idle_q;
  logic sleep_q;
  always_ff @(posedge CLK_SYS) begin
    if (RESET || ACTIVITY || sleep_tmr_q == SLEEP_NEVER) begin
      idle_sub_q <= 7'h00;
    end else if (tick) begin
      if (idle_sub_q == 7'(TICKS_PER_SEC - 1)) begin
        idle_sub_q <= 7'h00;
      end else begin
        idle_sub_q <= idle_sub_q + 7'h01;
      end
    end
  end
  assign idle_sec = tick && idle_sub_q == 7'(TICKS_PER_SEC - 1);

  always_ff @(posedge CLK_SYS) begin
    if (RESET || ACTIVITY || sleep_tmr_q == SLEEP_NEVER) begin
      idle_q <= 8'h00;
    end else if (idle_sec && idle_q != 8'hFF) begin
      idle_q <= idle_q + 8'h01;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RESET || ACTIVITY || sleep_tmr_q == SLEEP_NEVER) begin
      sleep_q <= 1'b0;
    end else if (idle_q >= sleep_tmr_q) begin
      sleep_q <= 1'b1;
    end
  end
  assign SLEEP_ENTER = sleep_q;

  // ****************************************
  // terminal-ready post-connect delay
  // ****************************************
  // only sync mode one waits; other modes see the line at once
  logic [6:0] conn_sub_q;
  logic conn_sec;
  logic [7:0] conn_q;
  logic valid_q;
  always_ff @(posedge CLK_SYS) begin
    if (RESET || !CONNECTED) begin
      conn_sub_q <= 7'h00;
    end else if (tick) begin
      if (conn_sub_q == 7'(TICKS_PER_SEC - 1)) begin
        conn_sub_q <= 7'h00;
      end else begin
        conn_sub_q <= conn_sub_q + 7'h01;
      end
    end
  end
  assign conn_sec = tick && conn_sub_q == 7'(TICKS_PER_SEC - 1);

  always_ff @(posedge CLK_SYS) begin
    if (RESET || !CONNECTED) begin
      conn_q <= 8'h00;
    end else if (conn_sec && conn_q != 8'hFF) begin
      conn_q <= conn_q + 8'h01;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RESET || !CONNECTED) begin
      valid_q <= 1'b0;
    end else if (comm_f != 3'h1 || conn_q >= trdy_dly_q) begin
      valid_q <= 1'b1;
    end
  end
  assign TERMINAL_READY_VALID = valid_q;

  mor_filter u_filter (
    .clk(CLK_SYS),
    .rst(RESET),
    .tick(tick),
    .enable(ON_LINE),
    .hold_ticks(trdy_dly_q),
    .raw(TERMINAL_READY),
    .filtered(TERMINAL_READY_FILT)
  );

  // ****************************************
  // read port
  // ****************************************
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      REG_RDATA <= 8'h00;
    end else if (REG_RD) begin
      case (REG_ADDR)
        LOOP_RATE_OFS: REG_RDATA <= loop_rate_q;
        SLEEP_TMR_OFS: REG_RDATA <= sleep_tmr_q;
        TRDY_DLY_OFS: REG_RDATA <= trdy_dly_q;
        RTS_DLY_OFS: REG_RDATA <= RTS_DLY_RST;
        MODE_OFS: REG_RDATA <= mode_q;
        STATUS_OFS: REG_RDATA <= {5'h00, TERMINAL_READY_FILT,
                                  valid_q, sleep_q};
        default: REG_RDATA <= 8'h00;
      endcase
    end
  end
endmodule

// ### mor_pkg.sv
// package of offsets, field layouts, reset values and timing counts
package mor_pkg;
  // ****************************************
  // register offsets
  // ****************************************
  localparam logic [2:0] LOOP_RATE_OFS = 3'h0;
  localparam logic [2:0] SLEEP_TMR_OFS = 3'h1;
  localparam logic [2:0] TRDY_DLY_OFS = 3'h2;
  localparam logic [2:0] RTS_DLY_OFS = 3'h3;
  localparam logic [2:0] MODE_OFS = 3'h4;
  localparam logic [2:0] STATUS_OFS = 3'h5;
  // ****************************************
  // reset values
  // ****************************************
  localparam logic [7:0] LOOP_RATE_RST = 8'h07;
  localparam logic [7:0] SLEEP_TMR_RST = 8'h00;
  localparam logic [7:0] TRDY_DLY_RST = 8'h05;
  localparam logic [7:0] RTS_DLY_RST = 8'h01;
  localparam logic [7:0] MODE_RST = 8'h40;
  // ****************************************
  // field positions and codes
  // ****************************************
  localparam int RDL_BIT = 0;
  localparam int RATE_LO = 1;
  localparam int PAR_LO = 4;
  localparam int GUARD_LO = 6;
  localparam int LINE_BIT = 2;
  localparam int CLK_LO = 4;
  localparam int STD_BIT = 6;
  localparam int DISCRIM_BIT = 7;
  localparam logic [1:0] RATE_300 = 2'h0;
  localparam logic [1:0] RATE_1200 = 2'h2;
  localparam logic [1:0] RATE_2400 = 2'h3;
  localparam logic [1:0] PAR_EVEN = 2'h0;
  localparam logic [1:0] PAR_SPACE = 2'h1;
  localparam logic [1:0] CLK_INTERNAL = 2'h0;
  localparam logic [7:0] SLEEP_NEVER = 8'hFF;
  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_HZ = 100_000_000;
  localparam int TICK_MS = 10;
  localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
  localparam int TICKS_PER_SEC = 100;
endpackage

// ### mor_tick.sv
// periodic one-cycle tick generator
`timescale 1ns/1ps
module mor_tick #(
  parameter int PERIOD = 1000000
) (
  input wire logic clk,
  input wire logic rst,
  output logic tick
);
  logic [31:0] cnt_q;
  always_ff @(posedge clk) begin
    if (rst || cnt_q == 32'(PERIOD - 1)) begin
      cnt_q <= 32'h0;
    end else begin
      cnt_q <= cnt_q + 32'h1;
    end
  end
  assign tick = (cnt_q == 32'(PERIOD - 1));
endmodule

// ### mor_filter.sv
// terminal-ready change filter: accepts a level held for a tick count
`timescale 1ns/1ps
module mor_filter (
  input wire logic clk,
  input wire logic rst,
  input wire logic tick,
  input wire logic enable,
  input wire logic [7:0] hold_ticks,
  input wire logic raw,
  output logic filtered
);
  logic [7:0] cnt_q;
  logic filt_q;
  always_ff @(posedge clk) begin
    if (rst) begin
      filt_q <= 1'b0;
      cnt_q <= 8'h00;
    end else if (!enable || raw == filt_q) begin
      cnt_q <= 8'h00;
      if (!enable) begin
        filt_q <= raw;
      end
    end else if (tick) begin
      // short changes never reach the output while enable is high; with enable low raw is copied to the output on each clock edge
      if (cnt_q + 8'h01 >= hold_ticks) begin
        filt_q <= raw;
        cnt_q <= 8'h00;
      end else begin
        cnt_q <= cnt_q + 8'h01;
      end
    end
  end
  assign filtered = filt_q;
endmodule

// ### mor_host_model.sv
// host terminal model that issues guard-tone and discrimination commands
`timescale 1ns/1ps
module mor_host_model (
  input wire logic clk,
  output logic guard_cmd,
  output logic [1:0] guard_val,
  output logic disc_cmd,
  output logic disc_set
);
  initial begin
    guard_cmd = 1'b0;
    guard_val = 2'h0;
    disc_cmd = 1'b0;
    disc_set = 1'b0;
  end
  // released values are inverted so a stale level is never mistaken
  task send_guard(input logic [1:0] v);
    @(posedge clk);
    guard_val <= v;
    guard_cmd <= 1'b1;
    @(posedge clk);
    guard_cmd <= 1'b0;
    guard_val <= ~v;
  endtask
  task send_discrim(input logic s);
    @(posedge clk);
    disc_set <= s;
    disc_cmd <= 1'b1;
    @(posedge clk);
    disc_cmd <= 1'b0;
    disc_set <= ~s;
  endtask
endmodule

// ### mor_checker.sv
// concurrent checks on the option register bank ports
`timescale 1ns/1ps
module mor_checker (
  input wire logic CLK_SYS,
  input wire logic RESET,
  input wire logic FACTORY_DEFAULTS,
  input wire logic [2:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [7:0] REG_RDATA,
  input wire logic AUTO_ANSWER_DISCRIM_CMD,
  input wire logic AUTO_ANSWER_DISCRIM_SET,
  input wire logic [1:0] GUARD_TONE_VALUE,
  input wire logic GUARD_TONE_CMD,
  input wire logic [1:0] LINE_RATE,
  input wire logic [1:0] PARITY_SEL,
  input wire logic [1:0] GUARD_TONE_SEL,
  input wire logic SYNC_MODE,
  input wire logic LEASED_LINE,
  input wire logic [1:0] TX_CLOCK_SRC,
  input wire logic BELL_STANDARD,
  input wire logic DISCRIM_ENABLE
);
  logic wr0;
  logic wr4;
  // commands win over a same-cycle write, so those cycles are left out
  assign wr0 = REG_WR && REG_ADDR == 3'h0 && !GUARD_TONE_CMD
    && !FACTORY_DEFAULTS;
  assign wr4 = REG_WR && REG_ADDR == 3'h4 && !AUTO_ANSWER_DISCRIM_CMD
    && !FACTORY_DEFAULTS;
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RESET);
  rate_map_a: assert property (wr0 |=> ##1 LINE_RATE ==
    (($past(REG_WDATA[2:1], 2) == 2'h1) ? 2'h3 : $past(REG_WDATA[2:1], 2)))
    else $error("line rate does not follow write");
  parity_sel_a: assert property (wr0 |=> ##1
    PARITY_SEL == $past(REG_WDATA[5:4], 2)) else $error("parity mismatch");
  guard_cmd_a: assert property (GUARD_TONE_CMD && !FACTORY_DEFAULTS
    |=> ##1 GUARD_TONE_SEL == $past(GUARD_TONE_VALUE, 2))
    else $error("guard tone");
  no_sync_a: assert property (!SYNC_MODE && !LEASED_LINE
    && TX_CLOCK_SRC == 2'h0) else $error("unsupported mode driven");
  bell_std_a: assert property (wr4 |=> ##1
    BELL_STANDARD == $past(REG_WDATA[6], 2)) else $error("standard mismatch");
  discrim_cmd_a: assert property (AUTO_ANSWER_DISCRIM_CMD
    && !FACTORY_DEFAULTS |=> ##1
    DISCRIM_ENABLE == $past(AUTO_ANSWER_DISCRIM_SET, 2))
    else $error("discrimination mismatch");
  factory_restore_a: assert property (FACTORY_DEFAULTS |=> ##1
    LINE_RATE == 2'h3 && BELL_STANDARD == 1'b1 && PARITY_SEL == 2'h0)
    else $error("defaults not restored");
  unmapped_read_a: assert property (REG_RD && REG_ADDR[2:1] == 2'h3 |=>
    REG_RDATA == 8'h00) else $error("unmapped read not zero");
endmodule
bind mor_top mor_checker u_chk (.*);

// ### testbench.sv
// self-checking bench for the modem option register bank
`timescale 1ns/1ps
module testbench;
  import mor_pkg::*;
  logic CLK_SYS = 1'b0, RESET = 1'b1, FACTORY_DEFAULTS = 1'b0;
  logic REG_WR = 1'b0, REG_RD = 1'b0, ACTIVITY = 1'b1, CONNECTED = 1'b0;
  logic ON_LINE = 1'b0, TERMINAL_READY = 1'b0, REMOTE_LOOP_REQ = 1'b1;
  logic [2:0] REG_ADDR = 3'h0;
  logic [7:0] REG_WDATA = 8'h00, REG_RDATA;
  logic AUTO_ANSWER_DISCRIM_CMD, AUTO_ANSWER_DISCRIM_SET, GUARD_TONE_CMD;
  logic REMOTE_LOOP_ACCEPT, SYNC_MODE, LEASED_LINE, BELL_STANDARD;
  logic DISCRIM_ENABLE, SLEEP_ENTER, TERMINAL_READY_VALID, TERMINAL_READY_FILT;
  logic [1:0] GUARD_TONE_VALUE, LINE_RATE, PARITY_SEL, GUARD_TONE_SEL;
  logic [1:0] TX_CLOCK_SRC;
  int num_errors = 0, n_tests = 0, cycles = 0;
  always #5 CLK_SYS = ~CLK_SYS;
  mor_host_model host (.clk(CLK_SYS), .guard_cmd(GUARD_TONE_CMD),
    .guard_val(GUARD_TONE_VALUE), .disc_cmd(AUTO_ANSWER_DISCRIM_CMD),
    .disc_set(AUTO_ANSWER_DISCRIM_SET));
  // short tick keeps a one second sleep count near a thousand cycles
  mor_top #(.TICK_PERIOD(10)) uut (.*);
  task chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge CLK_SYS);
    #1;
  endtask
  task wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge CLK_SYS);
    REG_ADDR <= a;
    REG_WDATA <= d;
    REG_WR <= 1'b1;
    @(posedge CLK_SYS);
    REG_WR <= 1'b0;
  endtask
  task rd(input logic [2:0] a, input logic [7:0] e);
    @(posedge CLK_SYS);
    REG_ADDR <= a;
    REG_RD <= 1'b1;
    @(posedge CLK_SYS);
    REG_RD <= 1'b0;
    #1 chk(REG_RDATA, e);
  endtask
  task finish_test;
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  always @(posedge CLK_SYS) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      finish_test;
    end
  end
  initial begin
    repeat (5) @(posedge CLK_SYS);
    RESET <= 1'b0;
    rd(3'h0, 8'h07);
    rd(3'h1, 8'h00);
    rd(3'h2, 8'h05);
    rd(3'h3, 8'h01);
    rd(3'h4, 8'h40);
    chk({6'h00, LINE_RATE}, 8'h03);
    wr(3'h0, 8'h12);
    wr(3'h3, 8'hAA);
    wr(3'h6, 8'h55);
    cyc(3);
    chk({7'h00, REMOTE_LOOP_ACCEPT}, 8'h00);
    chk({4'h0, LINE_RATE, PARITY_SEL}, 8'h0D);
    rd(3'h0, 8'h12);
    rd(3'h3, 8'h01);
    rd(3'h6, 8'h00);
    wr(3'h0, 8'h01);
    cyc(3);
    chk({4'h0, LINE_RATE, 1'b0, REMOTE_LOOP_ACCEPT}, 8'h01);
    REMOTE_LOOP_REQ <= 1'b0;
    cyc(2);
    chk({7'h00, REMOTE_LOOP_ACCEPT}, 8'h00);
    REMOTE_LOOP_REQ <= 1'b1;
    host.send_guard(2'h2);
    cyc(3);
    chk({6'h00, GUARD_TONE_SEL}, 8'h02);
    rd(3'h0, 8'h81);
    wr(3'h4, 8'h3F);
    host.send_discrim(1'b1);
    cyc(3);
    chk({4'h0, SYNC_MODE, LEASED_LINE, TX_CLOCK_SRC}, 8'h00);
    chk({6'h00, BELL_STANDARD, DISCRIM_ENABLE}, 8'h01);
    rd(3'h4, 8'hBF);
    FACTORY_DEFAULTS <= 1'b1;
    cyc(1);
    FACTORY_DEFAULTS <= 1'b0;
    rd(3'h0, 8'h07);
    rd(3'h4, 8'h40);
    wr(3'h1, 8'h01);
    ACTIVITY <= 1'b0;
    cyc(900);
    chk({7'h00, SLEEP_ENTER}, 8'h00);
    cyc(200);
    chk({7'h00, SLEEP_ENTER}, 8'h01);
    rd(3'h5, 8'h01);
    ACTIVITY <= 1'b1;
    cyc(2);
    chk({7'h00, SLEEP_ENTER}, 8'h00);
    wr(3'h1, 8'hFF);
    ACTIVITY <= 1'b0;
    cyc(1500);
    chk({7'h00, SLEEP_ENTER}, 8'h00);
    wr(3'h2, 8'h03);
    CONNECTED <= 1'b1;
    ON_LINE <= 1'b1;
    cyc(3);
    chk({7'h00, TERMINAL_READY_VALID}, 8'h01);
    TERMINAL_READY <= 1'b1;
    cyc(10);
    TERMINAL_READY <= 1'b0;
    cyc(60);
    chk({7'h00, TERMINAL_READY_FILT}, 8'h00);
    TERMINAL_READY <= 1'b1;
    cyc(60);
    chk({7'h00, TERMINAL_READY_FILT}, 8'h01);
    CONNECTED <= 1'b0;
    wr(3'h4, 8'h41);
    wr(3'h2, 8'h01);
    CONNECTED <= 1'b1;
    cyc(900);
    chk({7'h00, TERMINAL_READY_VALID}, 8'h00);
    cyc(200);
    chk({7'h00, TERMINAL_READY_VALID}, 8'h01);
    finish_test;
  end
endmodule
